/* File: hwc_core_properties.sv */
// Checker for the cursor core: held updates, control fields and fetch sequencing.
// Assumes it is bound to hwc_cursor_core and sees only that module's ports.
`default_nettype none
module hwc_core_properties (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        hostWrEn,
    input wire logic [3:0]  hostWrIndex,
    input wire logic [11:0] hostWrData,
    input wire logic        frameStart,
    input wire logic        fieldStart,
    input wire logic        interlaced,
    input wire logic [1:0]  memMode,
    input wire logic        monoText,
    input wire logic        curEnable,
    input wire logic [1:0]  patType,
    input wire logic [19:0] patAddr,
    input wire logic [5:0]  originX,
    input wire logic [5:0]  originY,
    input wire logic [10:0] posX,
    input wire logic [10:0] posY,
    input wire logic        fetchBusy,
    input wire logic        fetchDone,
    input wire logic        memRdReq,
    input wire logic [19:0] memCpuAddr,
    input wire logic [3:0]  memBank,
    input wire logic [1:0]  memMapSel,
    input wire logic        memRdAck
);
    // ==========================================
    // Update moment as seen at the ports
    wire upd = interlaced ? fieldStart : frameStart;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_reset_clear;
        $fell(reset) |-> (patAddr == 20'h0 && posX == 11'h0 && !curEnable && !fetchBusy && !memRdReq);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
    property p_addr_held;
        !$past(reset) && ($changed(patAddr) || $changed(originX) || $changed(originY)) |-> $past(upd);
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address or origin moved off an update");
    property p_pos_held;
        !$past(reset) && ($changed(posX) || $changed(posY)) |-> $past(upd);
    endproperty
    a_pos_held: assert property (p_pos_held) else $error("position moved off an update");
    property p_ctrl_now;
        hostWrEn && hostWrIndex == 4'h0 |=> curEnable == $past(hostWrData[11]) && patType == $past(hostWrData[10:9]);
    endproperty
    a_ctrl_now: assert property (p_ctrl_now) else $error("control fields not taken");
    property p_first_req;
        $rose(fetchBusy) |=> (memRdReq || fetchDone);
    endproperty
    a_first_req: assert property (p_first_req) else $error("first read late");
    property p_map0;
        $rose(fetchBusy) ##1 memRdReq |-> memMapSel == 2'h0;
    endproperty
    a_map0: assert property (p_map0) else $error("pattern does not start in map 0");
    property p_ack_next;
        memRdAck && fetchBusy |-> ##2 (memRdReq || fetchDone);
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no follow-up after answer");
    property p_req_pulse;
        memRdReq |=> !memRdReq;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("read request longer than one cycle");
    property p_done_end;
        fetchDone |=> !fetchDone && !fetchBusy;
    endproperty
    a_done_end: assert property (p_done_end) else $error("fetch did not end");
    property p_text_base;
        memRdReq && memMode[1] |-> memBank == 4'h0 && memCpuAddr[19:15] == (monoText ? 5'h16 : 5'h17);
    endproperty
    a_text_base: assert property (p_text_base) else $error("text read outside its window");
    property p_gfx_base;
        memRdReq && !memMode[1] |-> memCpuAddr[19:16] == 4'ha;
    endproperty
    a_gfx_base: assert property (p_gfx_base) else $error("graphics read outside its window");
endmodule
bind hwc_cursor_core hwc_core_properties i_props (
    .ref_clk, .reset, .hostWrEn, .hostWrIndex, .hostWrData, .frameStart, .fieldStart, .interlaced,
    .memMode, .monoText, .curEnable, .patType, .patAddr, .originX, .originY, .posX, .posY,
    .fetchBusy, .fetchDone, .memRdReq, .memCpuAddr, .memBank, .memMapSel, .memRdAck
);
`default_nettype wire

/* File: hwc_cursor_core.v */
// Hardware cursor register holding, pattern address translation and row fetch.
// Assumes the host write/read port, frame and field pulses, the memory answer and the
// pixel column all come from logic on ref_clk, so none is resynchronised.
`include "hwc_defs.vh"
`default_nettype none

// Notes on behaviour
// - Address and origin writes wait for a control write, then the next frame start.
// - Reading a held register returns its last written value, applied or not.
// - Position writes apply at the next frame start without a control write.
// - When interlaced, held updates apply at the next field start instead.
// - A pattern starts in map 0 and fills all four maps contiguously.
// - Pattern address is a doubleword start location, not a byte address.
// - Fetch 1K bytes for 64x64 or 256 bytes for 32x32 from the start.
// - Planar: each step is the next CPU byte over maps 0-3; bank 1 at 10000.
// - Packed: each value covers four CPU bytes; bank 1 at 4000, max 3FFFF.
// - Packed: map chosen by the two low CPU address bits.
// - Text: value spans a byte pair in maps 0:1 and 2:3; next at B8002.
// - Text mode 7 uses the B0000-B7FFE range.
// - 64x64: four bytes per offset, AND/XOR pairs, four offsets per row.
// - Most significant bit of a pattern byte is the leftmost column.
// - Fetch offsets are added to the pattern address value.
// - 32x32: same layout, two offsets per row, offsets 0 to 63.
// - Pattern type 00 is 32x32, 01 is 64x64, others reserved.
// - Cursor pixel high bit from the AND plane, low bit from XOR.
module hwc_cursor_core (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        hostWrEn,
    input  wire [3:0]  hostWrIndex,
    input  wire [11:0] hostWrData,
    input  wire [3:0]  hostRdIndex,
    output reg  [11:0] hostRdData,
    input  wire        frameStart,
    input  wire        fieldStart,
    input  wire        interlaced,
    input  wire [1:0]  memMode,
    input  wire        monoText,
    output reg         curEnable,
    output reg  [1:0]  patType,
    output reg         planeProt,
    output reg  [2:0]  colorMode,
    output reg  [19:0] patAddr,
    output reg  [5:0]  originX,
    output reg  [5:0]  originY,
    output reg  [10:0] posX,
    output reg  [10:0] posY,
    output reg  [7:0]  priColor,
    output reg  [7:0]  secColor,
    output reg  [7:0]  auxColor,
    input  wire        fetchStart,
    input  wire [5:0]  fetchRow,
    output reg         fetchBusy,
    output reg         fetchDone,
    output reg         memRdReq,
    output reg  [19:0] memCpuAddr,
    output reg  [3:0]  memBank,
    output reg  [1:0]  memMapSel,
    input  wire        memRdAck,
    input  wire [7:0]  memRdData,
    input  wire [5:0]  pixCol,
    output reg  [1:0]  pixOut
);

    // ==========================================
    // Fetch state machine codes
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_ISSUE = 4'b0010;
    localparam [3:0] ST_WAIT  = 4'b0100;
    localparam [3:0] ST_DONE  = 4'b1000;

    // Picks one column bit of a pattern byte, leftmost column in bit 7
    function pickBit;
        input [7:0] data;
        input [2:0] col;
        begin
            pickBit = data[3'h7 - col];
        end
    endfunction

    // ==========================================
    // Host-written shadow copies
    reg  [11:0] ctrl_r;
    reg  [11:0] patLo_r;
    reg  [11:0] patHi_r;
    reg  [11:0] origin_r;
    reg  [11:0] posXSh_r;
    reg  [11:0] posYSh_r;
    reg         addrPend_r;
    wire        updatePulse;
    wire        wrCtrl;

    assign updatePulse = interlaced ? fieldStart : frameStart;
    assign wrCtrl      = hostWrEn && (hostWrIndex == `HWC_IDX_CTRL);

    always @(posedge ref_clk) begin
        if (reset) begin
            ctrl_r   <= `HWC_RESET_VALUE;
            patLo_r  <= `HWC_RESET_VALUE;
            patHi_r  <= `HWC_RESET_VALUE;
            origin_r <= `HWC_RESET_VALUE;
            posXSh_r <= `HWC_RESET_VALUE;
            posYSh_r <= `HWC_RESET_VALUE;
            priColor <= 8'h00;
            secColor <= 8'h00;
            auxColor <= 8'h00;
        end else if (hostWrEn) begin
            if (hostWrIndex == `HWC_IDX_CTRL) begin
                ctrl_r <= hostWrData & `HWC_CTRL_WMASK;
            end else if (hostWrIndex == `HWC_IDX_PAT_LO) begin
                patLo_r <= hostWrData;
            end else if (hostWrIndex == `HWC_IDX_PAT_HI) begin
                patHi_r <= hostWrData & `HWC_PAT_HI_MASK;
            end else if (hostWrIndex == `HWC_IDX_PRI_COLOR) begin
                priColor <= hostWrData[7:0];
            end else if (hostWrIndex == `HWC_IDX_SEC_COLOR) begin
                secColor <= hostWrData[7:0];
            end else if (hostWrIndex == `HWC_IDX_ORIGIN) begin
                origin_r <= hostWrData;
            end else if (hostWrIndex == `HWC_IDX_POS_X) begin
                posXSh_r <= hostWrData & `HWC_POS_MASK;
            end else if (hostWrIndex == `HWC_IDX_POS_Y) begin
                posYSh_r <= hostWrData & `HWC_POS_MASK;
            end else if (hostWrIndex == `HWC_IDX_AUX_COLOR) begin
                auxColor <= hostWrData[7:0];
            end
        end
    end

    // Control fields act at once; only address and origin wait for it
    always @(posedge ref_clk) begin
        if (reset) begin
            curEnable <= 1'b0;
            patType   <= 2'h0;
            planeProt <= 1'b0;
            colorMode <= 3'h0;
        end else if (wrCtrl) begin
            curEnable <= hostWrData[`HWC_CTRL_ENABLE];
            patType   <= hostWrData[`HWC_CTRL_TYPE_HI:`HWC_CTRL_TYPE_LO];
            planeProt <= hostWrData[`HWC_CTRL_PROT];
            colorMode <= hostWrData[`HWC_CTRL_CMODE_HI:`HWC_CTRL_CMODE_LO];
        end
    end

    // A control write in the same cycle as the update pulse keeps the flag set,
    // so its values go out at the following frame rather than being lost.
    always @(posedge ref_clk) begin
        if (reset) begin
            addrPend_r <= 1'b0;
        end else if (wrCtrl) begin
            addrPend_r <= 1'b1;
        end else if (updatePulse) begin
            addrPend_r <= 1'b0;
        end
    end

    // ==========================================
    // Working registers, loaded at frame or field start
    always @(posedge ref_clk) begin
        if (reset) begin
            patAddr <= 20'h00000;
            originX <= 6'h00;
            originY <= 6'h00;
            posX    <= 11'h000;
            posY    <= 11'h000;
        end else if (updatePulse) begin
            posX <= posXSh_r[10:0];
            posY <= posYSh_r[10:0];
            if (addrPend_r && !wrCtrl) begin
                patAddr <= {patHi_r[7:0], patLo_r};
                originX <= origin_r[5:0];
                originY <= origin_r[11:6];
            end
        end
    end

    // Readback shows the shadow of each held register, never its working copy; the colors have only one copy
    always @(posedge ref_clk) begin
        if (reset) begin
            hostRdData <= `HWC_RESET_VALUE;
        end else if (hostRdIndex == `HWC_IDX_CTRL) begin
            hostRdData <= ctrl_r;
        end else if (hostRdIndex == `HWC_IDX_PAT_LO) begin
            hostRdData <= patLo_r;
        end else if (hostRdIndex == `HWC_IDX_PAT_HI) begin
            hostRdData <= patHi_r;
        end else if (hostRdIndex == `HWC_IDX_PRI_COLOR) begin
            hostRdData <= {4'h0, priColor};
        end else if (hostRdIndex == `HWC_IDX_SEC_COLOR) begin
            hostRdData <= {4'h0, secColor};
        end else if (hostRdIndex == `HWC_IDX_ORIGIN) begin
            hostRdData <= origin_r;
        end else if (hostRdIndex == `HWC_IDX_POS_X) begin
            hostRdData <= posXSh_r;
        end else if (hostRdIndex == `HWC_IDX_POS_Y) begin
            hostRdData <= posYSh_r;
        end else if (hostRdIndex == `HWC_IDX_AUX_COLOR) begin
            hostRdData <= {4'h0, auxColor};
        end else begin
            hostRdData <= `HWC_RESET_VALUE;
        end
    end

    // ==========================================
    // Row fetch sequencer
    reg  [3:0]  state_r;
    reg  [5:0]  row_r;
    reg  [1:0]  offIdx_r;
    reg  [1:0]  byteIdx_r;
    reg         is64_r;
    wire [7:0]  offset;
    wire [19:0] loc;
    wire [2:0]  offsPerRow;
    wire        lastByte;
    wire        typeValid;

    assign typeValid  = (patType == `HWC_TYPE_32) || (patType == `HWC_TYPE_64);
    assign offsPerRow = is64_r ? `HWC_OFFS_64 : `HWC_OFFS_32;
    // Row offsets: 4 per row over 0..255, or 2 per row over 0..63
    assign offset = is64_r ? ({row_r, offIdx_r} & `HWC_LAST_OFF_64)
                           : ({1'b0, row_r[4:0], offIdx_r[0]} & `HWC_LAST_OFF_32);
    assign loc      = patAddr + {12'h000, offset};
    assign lastByte = (byteIdx_r == 2'h3) && ({1'b0, offIdx_r} == offsPerRow - 3'h1);

    // Byte order within one offset starts at map 0 and walks maps 0..3
    always @(posedge ref_clk) begin
        if (reset) begin
            state_r   <= ST_IDLE;
            row_r     <= 6'h00;
            offIdx_r  <= 2'h0;
            byteIdx_r <= 2'h0;
            is64_r    <= 1'b0;
            fetchBusy <= 1'b0;
            fetchDone <= 1'b0;
            memRdReq  <= 1'b0;
        end else begin
            fetchDone <= 1'b0;
            memRdReq  <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (fetchStart) begin
                        row_r     <= fetchRow;
                        offIdx_r  <= 2'h0;
                        byteIdx_r <= 2'h0;
                        is64_r    <= (patType == `HWC_TYPE_64);
                        fetchBusy <= 1'b1;
                        // Reserved pattern types fetch nothing
                        state_r   <= typeValid ? ST_ISSUE : ST_DONE;
                    end
                end
                ST_ISSUE: begin
                    memRdReq <= 1'b1;
                    state_r  <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (memRdAck) begin
                        if (lastByte) begin
                            state_r <= ST_DONE;
                        end else begin
                            byteIdx_r <= byteIdx_r + 2'h1;
                            if (byteIdx_r == 2'h3) begin
                                offIdx_r <= offIdx_r + 2'h1;
                            end
                            state_r <= ST_ISSUE;
                        end
                    end
                end
                ST_DONE: begin
                    fetchBusy <= 1'b0;
                    fetchDone <= 1'b1;
                    state_r   <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Pattern location to CPU address, bank and map
    reg [19:0] cpuNxt;
    reg [3:0]  bankNxt;
    reg [1:0]  mapNxt;

    always @* begin
        cpuNxt  = `HWC_BASE_GRAPHICS;
        bankNxt = 4'h0;
        mapNxt  = byteIdx_r;
        if (memMode == `HWC_MODE_PLANAR) begin
            cpuNxt  = `HWC_BASE_GRAPHICS | {4'h0, loc[15:0]};
            bankNxt = {3'h0, loc[16]};
        end else if (memMode == `HWC_MODE_PACKED) begin
            cpuNxt  = `HWC_BASE_GRAPHICS | {4'h0, loc[13:0], byteIdx_r};
            bankNxt = loc[17:14];
            mapNxt  = cpuNxt[1:0];
        end else begin
            // Each value covers a byte pair in maps 0:1 and again in maps 2:3
            cpuNxt = (monoText ? `HWC_BASE_MONO : `HWC_BASE_TEXT)
                     | {5'h00, loc[13:0], byteIdx_r[0]};
        end
    end

    always @(posedge ref_clk) begin
        if (reset) begin
            memCpuAddr <= 20'h00000;
            memBank    <= 4'h0;
            memMapSel  <= 2'h0;
        end else if (state_r == ST_ISSUE) begin
            memCpuAddr <= cpuNxt;
            memBank    <= bankNxt;
            memMapSel  <= mapNxt;
        end
    end

    // ==========================================
    // Row buffer and pixel output; pixel follows pixCol by two cycles
    wire [15:0] rowWord;
    wire [1:0]  wrByteEn;
    reg  [2:0]  colLow_r;

    // Even maps carry the AND plane, odd maps the XOR plane
    assign wrByteEn = (state_r == ST_WAIT && memRdAck) ?
                      (byteIdx_r[0] ? 2'h1 : 2'h2) : 2'h0;

    hwc_row_mem rowMem (
        .ref_clk  (ref_clk),
        .wrByteEn (wrByteEn),
        .wrEntry  ({offIdx_r, byteIdx_r[1]}),
        .wrData   (memRdData),
        .rdEntry  (pixCol[5:3]),
        .rdData   (rowWord)
    );

    always @(posedge ref_clk) begin
        if (reset) begin
            colLow_r <= 3'h0;
            pixOut   <= 2'h0;
        end else begin
            colLow_r <= pixCol[2:0];
            pixOut   <= {pickBit(rowWord[15:8], colLow_r), pickBit(rowWord[7:0], colLow_r)};
        end
    end

endmodule

`default_nettype wire

/* File: hwc_cursor_core_bench.sv */
// Self-checking bench for the cursor core: held updates, readback, fetch addressing, pixels.
// Assumes hwc_defs.vh on the include path, the memory model and the bound checker.
`include "hwc_defs.vh"
`default_nettype none
module hwc_cursor_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        hostWrEn = 1'b0;
    logic [3:0]  hostWrIndex = 4'h0;
    logic [11:0] hostWrData = 12'h000;
    logic [3:0]  hostRdIndex = 4'h0;
    logic        frameStart = 1'b0;
    logic        fieldStart = 1'b0;
    logic        interlaced = 1'b0;
    logic [1:0]  memMode = 2'h0;
    logic        monoText = 1'b0;
    logic        fetchStart = 1'b0;
    logic [5:0]  fetchRow = 6'h00;
    logic [5:0]  pixCol = 6'h00;
    wire  [11:0] hostRdData;
    wire         curEnable, fetchBusy, fetchDone, memRdReq, memRdAck;
    wire  [1:0]  patType, memMapSel, pixOut;
    wire  [19:0] patAddr, memCpuAddr;
    wire  [5:0]  originX, originY;
    wire  [10:0] posX, posY;
    wire  [3:0]  memBank;
    wire  [7:0]  memRdData;
    int          badCount = 0;
    int          totalChecks = 0;
    logic [7:0]  expByte [0:15];
    hwc_cursor_core i_dut (
        .ref_clk, .reset, .hostWrEn, .hostWrIndex, .hostWrData, .hostRdIndex, .hostRdData,
        .frameStart, .fieldStart, .interlaced, .memMode, .monoText, .curEnable, .patType,
        .planeProt(), .colorMode(), .patAddr, .originX, .originY, .posX, .posY, .priColor(),
        .secColor(), .auxColor(), .fetchStart, .fetchRow, .fetchBusy, .fetchDone, .memRdReq,
        .memCpuAddr, .memBank, .memMapSel, .memRdAck, .memRdData, .pixCol, .pixOut
    );
    hwc_mem_model i_mem (.ref_clk, .reset, .memRdReq, .memCpuAddr, .memBank, .memMapSel, .memRdAck, .memRdData);
    always #20 ref_clk = ~ref_clk;
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] idx, input logic [11:0] dat);
        @(posedge ref_clk);
        hostWrEn <= 1'b1;
        hostWrIndex <= idx;
        hostWrData <= dat;
        @(posedge ref_clk);
        hostWrEn <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [3:0] idx, input logic [11:0] exp);
        @(posedge ref_clk);
        hostRdIndex <= idx;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(hostRdData, exp);
    endtask
    task automatic pulse(input logic fld);
        @(posedge ref_clk);
        frameStart <= !fld;
        fieldStart <= fld;
        @(posedge ref_clk);
        frameStart <= 1'b0;
        fieldStart <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [7:0] mdat(input logic [19:0] a, input logic [3:0] bk, input logic [1:0] m);
        return a[7:0] ^ a[15:8] ^ {bk, 2'h0, m};
    endfunction
    task automatic fetch(input logic [1:0] mode, input logic mono, input logic [1:0] typ,
                         input logic [5:0] row, input logic [19:0] pa, input int npix);
        logic [19:0] loc, cpu;
        logic [3:0]  bank;
        logic [1:0]  bs;
        int          n, k, w, g, extra;
        n = (typ == `HWC_TYPE_64) ? 4 : (typ == `HWC_TYPE_32) ? 2 : 0;
        extra = 0;
        memMode <= mode;
        monoText <= mono;
        wr(`HWC_IDX_PAT_LO, pa[11:0]);
        wr(`HWC_IDX_PAT_HI, {4'h0, pa[19:12]});
        wr(`HWC_IDX_CTRL, {1'b1, typ, 9'h000});
        pulse(1'b0);
        chk(patType, typ);
        @(posedge ref_clk);
        fetchStart <= 1'b1;
        fetchRow <= row;
        @(posedge ref_clk);
        fetchStart <= 1'b0;
        #1;
        for (k = 0; k < n * 4; k++) begin
            for (w = 0; memRdReq !== 1'b1 && w < 20; w++) begin
                @(posedge ref_clk);
                #1;
            end
            loc = pa + 20'(row * n + k / 4);
            bs = 2'(k % 4);
            cpu = (mode == `HWC_MODE_PLANAR) ? (`HWC_BASE_GRAPHICS | {4'h0, loc[15:0]}) :
                  (mode == `HWC_MODE_PACKED) ? (`HWC_BASE_GRAPHICS | {4'h0, loc[13:0], bs}) :
                  ((mono ? `HWC_BASE_MONO : `HWC_BASE_TEXT) | {5'h0, loc[13:0], bs[0]});
            bank = (mode == `HWC_MODE_PLANAR) ? {3'h0, loc[16]} : (mode == `HWC_MODE_PACKED) ? loc[17:14] : 4'h0;
            chk(memCpuAddr, cpu);
            chk(memBank, bank);
            chk(memMapSel, bs);
            expByte[k] = mdat(cpu, bank, bs);
            @(posedge ref_clk);
            #1;
        end
        for (w = 0; fetchDone !== 1'b1 && w < 20; w++) begin
            if (memRdReq === 1'b1) extra++;
            @(posedge ref_clk);
            #1;
        end
        chk(w < 20, 1'b1);
        chk(20'(extra), 20'h0);
        for (g = 0; g < npix; g++) begin
            @(posedge ref_clk);
            pixCol <= 6'(g);
            repeat (3) @(posedge ref_clk);
            #1;
            k = (g / 16) * 4 + ((g / 8) % 2) * 2;
            chk(pixOut, {expByte[k][7 - g % 8], expByte[k + 1][7 - g % 8]});
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic test_reset();
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        chk(patAddr, 20'h0);
        chk({curEnable, posX, fetchBusy}, 20'h0);
        rdchk(`HWC_IDX_ORIGIN, `HWC_RESET_VALUE);
    endtask
    task automatic test_held();
        wr(`HWC_IDX_PAT_LO, 12'h123);
        wr(`HWC_IDX_PAT_HI, 12'hf45);
        wr(`HWC_IDX_ORIGIN, 12'h7c5);
        pulse(1'b0);
        chk(patAddr, 20'h0);
        rdchk(`HWC_IDX_PAT_HI, 12'h045);
        rdchk(`HWC_IDX_ORIGIN, 12'h7c5);
        wr(`HWC_IDX_PRI_COLOR, 12'hf3c);
        rdchk(`HWC_IDX_PRI_COLOR, 12'h03c);
        wr(`HWC_IDX_CTRL, 12'h000);
        chk(patAddr, 20'h0);
        pulse(1'b0);
        chk(patAddr, 20'h45123);
        chk({originY, originX}, 12'h7c5);
        wr(`HWC_IDX_POS_X, 12'hfab);
        chk(posX, 11'h0);
        pulse(1'b0);
        chk(posX, 11'h7ab);
    endtask
    task automatic test_interlace();
        interlaced <= 1'b1;
        wr(`HWC_IDX_POS_Y, 12'h155);
        wr(`HWC_IDX_PAT_LO, 12'h001);
        wr(`HWC_IDX_CTRL, 12'h000);
        pulse(1'b0);
        chk(posY, 11'h0);
        chk(patAddr, 20'h45123);
        pulse(1'b1);
        chk(posY, 11'h155);
        chk(patAddr, 20'h45001);
        interlaced <= 1'b0;
    endtask
    task automatic test_fetch_packed();
        fetch(`HWC_MODE_PACKED, 1'b0, `HWC_TYPE_64, 6'h01, 20'h03ffa, 64);
    endtask
    task automatic test_fetch_planar();
        fetch(`HWC_MODE_PLANAR, 1'b0, `HWC_TYPE_32, 6'h1f, 20'h0ffc1, 0);
    endtask
    task automatic test_fetch_text();
        fetch(`HWC_MODE_TEXT, 1'b0, `HWC_TYPE_64, 6'h3f, 20'h03f00, 0);
        fetch(`HWC_MODE_TEXT, 1'b1, `HWC_TYPE_32, 6'h00, 20'h00010, 0);
    endtask
    task automatic test_reserved();
        fetch(`HWC_MODE_PLANAR, 1'b0, 2'h2, 6'h00, 20'h00100, 0);
        fetch(`HWC_MODE_PACKED, 1'b0, 2'h3, 6'h00, 20'h00100, 0);
    endtask
    task automatic printVerdict();
        $display("checks=%0d mismatches=%0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        test_reset();
        test_held();
        test_interlace();
        test_fetch_packed();
        test_fetch_planar();
        test_fetch_text();
        test_reserved();
        test_reset();
        printVerdict();
    end
    // The run needs well under 3000 cycles; this limit leaves a wide margin
    initial begin
        #1000000;
        badCount++;
        printVerdict();
    end
endmodule
`default_nettype wire

/* File: hwc_defs.vh */
// Constants for the hardware cursor update and pattern fetch block.
// Assumes inclusion by bare name from the cursor core and its bench only.
`ifndef HWC_DEFS_VH
`define HWC_DEFS_VH

// ==========================================
// Register indexes of the cursor register file
`define HWC_IDX_CTRL      4'h0
`define HWC_IDX_PAT_LO    4'h1
`define HWC_IDX_PAT_HI    4'h2
`define HWC_IDX_PRI_COLOR 4'h3
`define HWC_IDX_SEC_COLOR 4'h4
`define HWC_IDX_ORIGIN    4'h5
`define HWC_IDX_POS_X     4'h6
`define HWC_IDX_POS_Y     4'h7
`define HWC_IDX_AUX_COLOR 4'h8

// ==========================================
// Control register fields
`define HWC_CTRL_ENABLE   11
`define HWC_CTRL_TYPE_HI  10
`define HWC_CTRL_TYPE_LO  9
`define HWC_CTRL_PROT     8
`define HWC_CTRL_CMODE_HI 7
`define HWC_CTRL_CMODE_LO 5
`define HWC_CTRL_WMASK    12'hfe0
`define HWC_TYPE_32       2'h0
`define HWC_TYPE_64       2'h1

// ==========================================
// Field masks and reset value of every held register
`define HWC_PAT_HI_MASK   12'h0ff
`define HWC_POS_MASK      12'h7ff
`define HWC_COLOR_MASK    12'h0ff
`define HWC_RESET_VALUE   12'h000

// ==========================================
// Memory organisation modes
`define HWC_MODE_PLANAR   2'h0
`define HWC_MODE_PACKED   2'h1
`define HWC_MODE_TEXT     2'h2

// ==========================================
// CPU window bases
`define HWC_BASE_GRAPHICS 20'ha0000
`define HWC_BASE_TEXT     20'hb8000
`define HWC_BASE_MONO     20'hb0000

// ==========================================
// Row geometry: offsets per row and last offset index
`define HWC_OFFS_64       3'h4
`define HWC_OFFS_32       3'h2
`define HWC_LAST_OFF_64   8'hff
`define HWC_LAST_OFF_32   8'h3f

`endif

/* File: hwc_mem_model.sv */
// Display memory stand-in that answers each pattern read, alternately at once or late.
// Assumes one-cycle requests on ref_clk with the address held until the next request.
`default_nettype none
module hwc_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        memRdReq,
    input  wire logic [19:0] memCpuAddr,
    input  wire logic [3:0]  memBank,
    input  wire logic [1:0]  memMapSel,
    output var  logic        memRdAck,
    output var  logic [7:0]  memRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow = 1'b0;
    // ==========================================
    // Answer
    always @(posedge ref_clk) begin
        if (reset) begin
            memRdAck <= 1'b0;
        end else if (memRdReq) begin
            if (slow) repeat (3) @(posedge ref_clk);
            slow <= !slow;
            memRdAck <= 1'b1;
            memRdData <= memCpuAddr[7:0] ^ memCpuAddr[15:8] ^ {memBank, 2'h0, memMapSel};
            @(posedge ref_clk);
            memRdAck <= 1'b0;
            // Data is not held after the answer, so a late capture shows a wrong byte
            memRdData <= ~memRdData;
        end
    end
endmodule
`default_nettype wire

/* File: hwc_row_mem.v */
// Row buffer: eight 16-bit entries, AND byte high, XOR byte low.
// Assumes one writer and one reader on the same clock; read data is registered.
`default_nettype none

module hwc_row_mem (
    input  wire        ref_clk,
    input  wire [1:0]  wrByteEn,
    input  wire [2:0]  wrEntry,
    input  wire [7:0]  wrData,
    input  wire [2:0]  rdEntry,
    output reg  [15:0] rdData
);

    reg [15:0] store [0:7];

    always @(posedge ref_clk) begin
        if (wrByteEn[1]) begin
            store[wrEntry][15:8] <= wrData;
        end
        if (wrByteEn[0]) begin
            store[wrEntry][7:0] <= wrData;
        end
        rdData <= store[rdEntry];
    end

endmodule

`default_nettype wire
